// ===== common/dbp_params.svh
// Offsets, field positions, reset values and limits of the bus protection block.
// Assumes voltages in units of 0.1 V and currents in whole percent of rated current.
`ifndef DBP_PARAMS_SVH
`define DBP_PARAMS_SVH

// ************************************************************
// Register indices; byte address is four times the index.
// ************************************************************
`define DBP_IDX_UV_THR    12'h600
`define DBP_IDX_OV_THR    12'h601
`define DBP_IDX_OV_METHOD 12'h602
`define DBP_IDX_OC_THR    12'h603
`define DBP_IDX_CTRL      12'h610
`define DBP_IDX_STATE     12'h611
`define DBP_IDX_IRQ_STS   12'h612
`define DBP_IDX_IRQ_MASK  12'h613

// ************************************************************
// Control and interrupt field positions.
// ************************************************************
`define DBP_CTRL_FAULT_RESET 0
`define DBP_CTRL_RESTART_EN  1
`define DBP_CTRL_TORQUE_CT   2
`define DBP_IRQ_UV_RUN       0
`define DBP_IRQ_UV_STOP      1
`define DBP_IRQ_OV_STALL     2
`define DBP_IRQ_OC_STALL     3
`define DBP_IRQ_RESTART      4
`define DBP_IRQ_W            5

// ************************************************************
// Voltage thresholds per class (0.1 V units).
// ************************************************************
`define DBP_UV_DEF_C0  16'h0708
`define DBP_UV_DEF_C1  16'h0e10
`define DBP_UV_DEF_C2  16'h1194
`define DBP_OV_DEF_C0  16'h0ed8
`define DBP_OV_DEF_C1  16'h1db0
`define DBP_OV_DEF_C2  16'h2616
`define DBP_HYST_C0    16'h012c
`define DBP_HYST_C1    16'h0258
`define DBP_HYST_C2    16'h02ee
`define DBP_CT_CAP_C0  16'h0dac
`define DBP_CT_CAP_C1  16'h1b58
`define DBP_CT_CAP_C2  16'h222e
`define DBP_SMART_BAND 16'h00c8
`define DBP_OV_METHOD_DEF 16'h0000

// ************************************************************
// Current limits (percent of rated current).
// ************************************************************
`define DBP_OC_DEF_VT  16'h0078
`define DBP_OC_MAX_VT  16'h0096
`define DBP_OC_MAX_CT  16'h00c8
`define DBP_OC_CAP_CT  16'h00b9

`endif

// ===== common/dbp_pkg.sv
// Types shared by the bus protection block.
// Assumes nothing of its surroundings.
package dbp_pkg;
  typedef enum logic [2:0] {
    DBP_CODE_NONE,
    DBP_CODE_UV_ACCEL,
    DBP_CODE_UV_DECEL,
    DBP_CODE_UV_CONST,
    DBP_CODE_UV_STOP
  } dbp_code_e;

  typedef enum logic [1:0] {
    DBP_ST_STOP,
    DBP_ST_RUN,
    DBP_ST_UV_FAULT,
    DBP_ST_UV_STOP
  } dbp_state_e;
endpackage : dbp_pkg

// ===== verif/dbp_plant.sv
// Ramp generator model beside the protection block.
// Assumes the bench commands run and ramp mode directly.
`timescale 1ns/10ps
module dbp_plant (
  // Commands from the bench.
  input  wire logic       run_request,
  input  wire logic [1:0] mode,
  // Ramp status to the block.
  output logic            ramp_accel,
  output logic            ramp_decel,
  output logic            ramp_decel_to_stop,
  output logic            motor_stopped
);
  // Mode 1 accelerates, 2 decelerates, 3 stops, 0 holds speed.
  assign ramp_accel         = run_request && mode == 2'h1;
  assign ramp_decel         = run_request && mode[1];
  assign ramp_decel_to_stop = run_request && mode == 2'h3;
  assign motor_stopped      = !run_request;
endmodule : dbp_plant

// ===== verif/dbp_top_bench.sv
// Self-checking bench of the bus protection block.
// Assumes class 0 defaults and the ramp model beside it.
`timescale 1ns/10ps
`include "dbp_params.svh"
module dbp_top_bench;
  import dbp_pkg::*;
  // Driven inputs.
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] v_set = 16'h0898;
  logic [15:0] i_set = 16'h0;
  logic        run_request = 1'b0;
  logic [1:0]  mode = 2'h0;
  // Observed outputs and bookkeeping.
  logic [31:0] prdata;
  logic        pready, pslverr, ramp_accel, ramp_decel, ramp_decel_to_stop, motor_stopped;
  logic        drive_enable, ramp_hold, decel_stretch, auto_restart;
  logic        undervolt_fault, undervolt_stop_notice, fault_log_strobe, irq;
  dbp_code_e   fault_code;
  logic [32:0] exp_q[$];
  logic [15:0] thr;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  dbp_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bus_voltage(v_set), .output_current(i_set), .run_request, .ramp_accel,
    .ramp_decel, .ramp_decel_to_stop, .motor_stopped, .drive_enable, .ramp_hold,
    .decel_stretch, .auto_restart, .fault_code, .undervolt_fault, .undervolt_stop_notice,
    .fault_log_strobe, .irq);
  dbp_plant u_plant (.run_request, .mode, .ramp_accel, .ramp_decel, .ramp_decel_to_stop,
    .motor_stopped);

  // ********
  // Tasks.
  // ********
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  // One bus transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Notes the expected {pslverr, prdata}, then reads.
  task automatic rd(input logic [11:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, idx, 32'h0);
  endtask : rd

  // Sets the pins, waits out the three-edge latency, reads the state word.
  task automatic step(input logic [15:0] v, input logic [15:0] i, input logic [32:0] e);
    v_set <= v;
    i_set <= i;
    repeat (4) @(posedge pclk);
    rd(`DBP_IDX_STATE, e);
  endtask : step

  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // ********
  // Processes.
  // ********
  // Clock and hang limit.
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  // Compares each read answer with the oldest noted expectation.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());

  // Main sequence.
  initial begin
    void'($urandom(90));
    thr = 16'(50 + $urandom_range(100));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DBP_IDX_UV_THR, 33'h708);
    rd(`DBP_IDX_OV_THR, 33'hed8);
    rd(`DBP_IDX_OV_METHOD, 33'h0);
    rd(`DBP_IDX_OC_THR, 33'h78);
    rd(12'h700, 33'h100000000);
    apb(1'b1, `DBP_IDX_OC_THR, {16'h0, thr});
    rd(`DBP_IDX_OC_THR, {17'h0, thr});
    run_request <= 1'b1;
    mode <= 2'h1;
    step(16'h0898, thr + 16'h1, 33'ha0);
    step(16'h0898, thr, 33'h20);
    apb(1'b1, `DBP_IDX_CTRL, 32'h4);
    apb(1'b1, `DBP_IDX_OC_THR, 32'hc8);
    step(16'h0e10, 16'hba, 33'ha0);
    step(16'h0e10, 16'hb9, 33'h20);
    mode <= 2'h2;
    step(16'h0ed9, 16'h0, 33'ha0);
    step(16'h0ed8, 16'h0, 33'h20);
    apb(1'b1, `DBP_IDX_OV_THR, 32'h0);
    step(16'h0ed9, 16'h0, 33'h20);
    apb(1'b1, `DBP_IDX_OV_THR, 32'hed8);
    apb(1'b1, `DBP_IDX_OV_METHOD, 32'h1);
    step(16'h0e74, 16'h0, 33'h20);
    chk({32'h0, decel_stretch}, 33'h1);
    mode <= 2'h3;
    step(16'h0ed9, 16'h0, 33'h1a0);
    step(16'h0898, 16'h0, 33'h120);
    apb(1'b1, `DBP_IDX_IRQ_STS, 32'h1f);
    apb(1'b1, `DBP_IDX_IRQ_MASK, 32'h1);
    for (int k = 1; k <= 3; k++) begin
      mode <= (k == 3) ? 2'h0 : 2'(k);
      step(16'h0898, 16'h0, 33'h20);
      step(16'h06a4, 16'h0, 33'(32'h41 | (k << 2)));
      step(16'h0898, 16'h0, 33'(32'h41 | (k << 2)));
      run_request <= 1'b0;
      apb(1'b1, `DBP_IDX_CTRL, 32'h1);
      step(16'h0898, 16'h0, 33'h0);
      run_request <= k < 3;
    end
    chk({32'h0, irq}, 33'h1);
    apb(1'b1, `DBP_IDX_IRQ_MASK, 32'h0);
    @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, `DBP_IDX_IRQ_STS, 32'h1f);
    apb(1'b1, `DBP_IDX_IRQ_MASK, 32'h1);
    chk({32'h0, irq}, 33'h0);
    step(16'h06a4, 16'h0, 33'h72);
    step(16'h0834, 16'h0, 33'h72);
    step(16'h0835, 16'h0, 33'h0);
    apb(1'b1, `DBP_IDX_CTRL, 32'h2);
    run_request <= 1'b1;
    step(16'h0898, 16'h0, 33'h20);
    step(16'h06a4, 16'h0, 33'h4d);
    step(16'h0898, 16'h0, 33'h20);
    end_of_test();
  end
endmodule : dbp_top_bench

// ===== verif/dbp_top_sva.sv
// Checker for the bus protection block, bound to its top module.
// Assumes only the top module's ports, one clock and a low reset.
`timescale 1ns/10ps
module dbp_top_sva (
  // Clock, reset and bus handshake.
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic               pready,
  // Ramp status and protection outputs.
  input wire logic               ramp_accel,
  input wire logic               ramp_decel,
  input wire logic               drive_enable,
  input wire logic               ramp_hold,
  input wire logic               decel_stretch,
  input wire logic               auto_restart,
  input wire dbp_pkg::dbp_code_e fault_code,
  input wire logic               undervolt_fault,
  input wire logic               undervolt_stop_notice,
  input wire logic               fault_log_strobe
);
  import dbp_pkg::*;
  // ********
  // Checks.
  // ********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A setup phase, then an answered access phase.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence

  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("access not answered after setup");
  a_uv_coast: assert property (undervolt_fault |-> !drive_enable)
    else $error("drive on during undervoltage fault");
  a_uv_code: assert property (undervolt_fault |-> fault_code inside
    {DBP_CODE_UV_ACCEL, DBP_CODE_UV_DECEL, DBP_CODE_UV_CONST})
    else $error("bad running fault code");
  a_fault_latch: assert property ($fell(undervolt_fault) |->
    auto_restart || $past(psel && penable && pwrite))
    else $error("fault cleared without reset or restart");
  a_notice_nolog: assert property (undervolt_stop_notice |->
    !fault_log_strobe && fault_code == DBP_CODE_UV_STOP)
    else $error("stop notice logged or miscoded");
  a_fault_logged: assert property ($rose(undervolt_fault) |-> ##[0:1] fault_log_strobe)
    else $error("running fault not logged");
  a_hold_cause: assert property (ramp_hold |->
    $past(drive_enable && (ramp_accel || ramp_decel)))
    else $error("ramp hold without ramp");
  a_stretch_cause: assert property (decel_stretch |-> $past(drive_enable && ramp_decel))
    else $error("stretch outside deceleration");
endmodule : dbp_top_sva

bind dbp_top dbp_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .ramp_accel, .ramp_decel, .drive_enable, .ramp_hold, .decel_stretch, .auto_restart,
  .fault_code, .undervolt_fault, .undervolt_stop_notice, .fault_log_strobe);

// ===== verilog/dbp_cmp.sv
// Unsigned magnitude comparator against a threshold.
// Assumes both operands share a unit and width.
`timescale 1ns/10ps
module dbp_cmp #(
  parameter int W = 17
) (
  // Operands.
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] limit,
  // Results.
  output logic              above,
  output logic              below
);
  // Strict compares on both sides; equality gives neither.
  assign above = value > limit;
  assign below = value < limit;
endmodule : dbp_cmp

// ===== verilog/dbp_sync.sv
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the pins change slowly against pclk, as sampled measurements do.
`timescale 1ns/10ps
module dbp_sync #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Raw and synchronised data.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // The first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : dbp_sync

// ===== verilog/dbp_top.sv
// Bus voltage and output current protection for a motor drive, with an APB slave.
// Assumes measurements arrive on pins and the ramp generator runs on pclk.
//
// What this block does
// - Undervoltage fault when bus voltage falls below programmed threshold; class defaults.
// - Undervoltage while running stops output drive at once; motor coasts.
// - Fault code tells acceleration, deceleration or constant speed at detection.
// - Running undervoltage fault stays latched until an explicit reset command.
// - With restart after power loss enabled, resume automatically after running fault.
// - Undervoltage while stopped gives a notice, never logged to fault history.
// - After stop notice, restart once voltage exceeds threshold plus class margin.
// - Zero over-voltage stall threshold disables over-voltage stall prevention.
// - Nonzero over-voltage stall threshold enables it and is the trip voltage.
// - Stall method field: 0 traditional, 1 smart; resets to 0.
// - Traditional: pause deceleration above threshold, resume once below.
// - Smart: regulate deceleration so bus voltage stays steady without trip.
// - Smart: overvoltage while stopping stretches deceleration until motor stopped.
// - During acceleration, hold frequency while current exceeds threshold.
// - Current threshold percent of rated: VT up to 150, CT up to 200.
// - CT with bus above class voltage caps current threshold at 185 percent.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "dbp_params.svh"
module dbp_top #(
  parameter int         VW        = 16,
  parameter logic [1:0] VOLT_CLASS = 2'h0
) (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Power stage measurements (pins).
  input  wire logic [VW-1:0]       bus_voltage,
  input  wire logic [15:0]         output_current,
  // Ramp generator status.
  input  wire logic                run_request,
  input  wire logic                ramp_accel,
  input  wire logic                ramp_decel,
  input  wire logic                ramp_decel_to_stop,
  input  wire logic                motor_stopped,
  // Drive and ramp control.
  output logic                     drive_enable,
  output logic                     ramp_hold,
  output logic                     decel_stretch,
  output logic                     auto_restart,
  // Fault reporting.
  output dbp_pkg::dbp_code_e       fault_code,
  output logic                     undervolt_fault,
  output logic                     undervolt_stop_notice,
  output logic                     fault_log_strobe,
  output logic                     irq
);
  import dbp_pkg::*;

  // ************************************************************
  // Class dependent constants.
  // ************************************************************
  localparam logic [15:0] UV_DEF = (VOLT_CLASS == 2'h2) ? `DBP_UV_DEF_C2 :
                                   (VOLT_CLASS == 2'h1) ? `DBP_UV_DEF_C1 : `DBP_UV_DEF_C0;
  localparam logic [15:0] OV_DEF = (VOLT_CLASS == 2'h2) ? `DBP_OV_DEF_C2 :
                                   (VOLT_CLASS == 2'h1) ? `DBP_OV_DEF_C1 : `DBP_OV_DEF_C0;
  localparam logic [15:0] HYST   = (VOLT_CLASS == 2'h2) ? `DBP_HYST_C2 :
                                   (VOLT_CLASS == 2'h1) ? `DBP_HYST_C1 : `DBP_HYST_C0;
  localparam logic [15:0] CT_CAP = (VOLT_CLASS == 2'h2) ? `DBP_CT_CAP_C2 :
                                   (VOLT_CLASS == 2'h1) ? `DBP_CT_CAP_C1 : `DBP_CT_CAP_C0;

  // ************************************************************
  // Registers and nets.
  // ************************************************************
  logic [15:0]          uv_thr_reg;
  logic [15:0]          ov_thr_reg;
  logic [15:0]          ov_method_reg;
  logic [15:0]          oc_thr_reg;
  logic                 restart_en_reg;
  logic                 torque_ct_reg;
  logic [`DBP_IRQ_W-1:0] irq_sts_reg;
  logic [`DBP_IRQ_W-1:0] irq_mask_reg;
  logic [`DBP_IRQ_W-1:0] irq_event;
  dbp_state_e           state_reg;
  dbp_state_e           state_next;
  logic                 stretch_latch_reg;
  logic [VW-1:0]        v_sync;
  logic [15:0]          i_sync;
  logic [16:0]          v_ext;
  logic [16:0]          i_ext;
  logic [16:0]          recover_lvl;
  logic [16:0]          smart_lvl;
  logic [15:0]          oc_eff;
  logic                 uv_below;
  logic                 uv_recover;
  logic                 uv_ok;
  logic                 ov_above;
  logic                 ov_near;
  logic                 ct_high;
  logic                 oc_above;
  logic                 ov_en;
  logic                 smart;
  logic                 ov_hold;
  logic                 oc_hold;
  logic                 apb_wr;
  logic                 apb_setup;
  logic [11:0]          idx;
  logic                 fault_reset;
  logic [1:0]           settle_reg;

  // ************************************************************
  // Measurement input synchronisers.
  // ************************************************************
  dbp_sync #(.W(VW)) u_sync_v (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bus_voltage),
    .q       (v_sync)
  );

  dbp_sync #(.W(16)) u_sync_i (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (output_current),
    .q       (i_sync)
  );

  // ************************************************************
  // Threshold comparisons.
  // ************************************************************
  // Levels are widened by one bit so that threshold plus margin never wraps.
  assign v_ext       = {1'b0, v_sync};
  assign i_ext       = {1'b0, i_sync};
  assign recover_lvl = {1'b0, uv_thr_reg} + {1'b0, HYST};
  assign smart_lvl   = (ov_thr_reg > `DBP_SMART_BAND) ?
                       {1'b0, ov_thr_reg - `DBP_SMART_BAND} : 17'h00000;
  assign ov_en       = ov_thr_reg != 16'h0000;
  assign smart       = ov_method_reg[0];

  dbp_cmp u_cmp_uv (
    .value (v_ext),
    .limit ({1'b0, uv_thr_reg}),
    .above (),
    .below (uv_below)
  );

  dbp_cmp u_cmp_uv_ok (
    .value (v_ext),
    .limit ({1'b0, uv_thr_reg} - 17'h00001),
    .above (uv_ok),
    .below ()
  );

  dbp_cmp u_cmp_rec (
    .value (v_ext),
    .limit (recover_lvl),
    .above (uv_recover),
    .below ()
  );

  dbp_cmp u_cmp_ov (
    .value (v_ext),
    .limit ({1'b0, ov_thr_reg}),
    .above (ov_above),
    .below ()
  );

  dbp_cmp u_cmp_smart (
    .value (v_ext),
    .limit (smart_lvl),
    .above (ov_near),
    .below ()
  );

  dbp_cmp u_cmp_ct (
    .value (v_ext),
    .limit ({1'b0, CT_CAP}),
    .above (ct_high),
    .below ()
  );

  // Effective current limit: the programmed value clipped to the mode maximum, or to 185 percent in CT with bus above class voltage.
  always_comb begin
    oc_eff = oc_thr_reg;
    if (torque_ct_reg) begin
      if (ct_high && oc_eff > `DBP_OC_CAP_CT) begin
        oc_eff = `DBP_OC_CAP_CT;
      end else if (oc_eff > `DBP_OC_MAX_CT) begin
        oc_eff = `DBP_OC_MAX_CT;
      end
    end else if (oc_eff > `DBP_OC_MAX_VT) begin
      oc_eff = `DBP_OC_MAX_VT;
    end
  end

  dbp_cmp u_cmp_oc (
    .value (i_ext),
    .limit ({1'b0, oc_eff}),
    .above (oc_above),
    .below ()
  );

  // ************************************************************
  // Run state machine.
  // ************************************************************
  assign fault_reset = apb_wr && idx == `DBP_IDX_CTRL && pwdata[`DBP_CTRL_FAULT_RESET];

  // Sync stages read zero just after reset; undervoltage waits two edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 2'h0;
    end else begin
      settle_reg <= {settle_reg[0], 1'b1};
    end
  end

  // Chooses the next run state from the undervoltage comparisons.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DBP_ST_STOP: begin
        if (uv_below && settle_reg[1]) begin
          state_next = DBP_ST_UV_STOP;
        end else if (run_request) begin
          state_next = DBP_ST_RUN;
        end
      end
      DBP_ST_RUN: begin
        if (uv_below && settle_reg[1]) begin
          state_next = DBP_ST_UV_FAULT;
        end else if (!run_request) begin
          state_next = DBP_ST_STOP;
        end
      end
      DBP_ST_UV_FAULT: begin
        if (restart_en_reg && uv_ok) begin
          state_next = DBP_ST_RUN;
        end else if (fault_reset) begin
          state_next = DBP_ST_STOP;
        end
      end
      DBP_ST_UV_STOP: begin
        if (uv_recover) begin
          state_next = DBP_ST_STOP;
        end
      end
      default: begin
        state_next = DBP_ST_STOP;
      end
    endcase
  end

  // Holds the run state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DBP_ST_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Drives the power stage only while running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enable <= 1'b0;
    end else begin
      drive_enable <= state_next == DBP_ST_RUN;
    end
  end

  // Fault code, fault flags, history strobe and restart pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_code            <= DBP_CODE_NONE;
      undervolt_fault       <= 1'b0;
      undervolt_stop_notice <= 1'b0;
      fault_log_strobe      <= 1'b0;
      auto_restart          <= 1'b0;
    end else begin
      fault_log_strobe <= 1'b0;
      auto_restart     <= 1'b0;
      if (state_reg == DBP_ST_RUN && state_next == DBP_ST_UV_FAULT) begin
        undervolt_fault  <= 1'b1;
        fault_log_strobe <= 1'b1;
        if (ramp_accel) begin
          fault_code <= DBP_CODE_UV_ACCEL;
        end else if (ramp_decel) begin
          fault_code <= DBP_CODE_UV_DECEL;
        end else begin
          fault_code <= DBP_CODE_UV_CONST;
        end
      end else if (state_reg == DBP_ST_STOP && state_next == DBP_ST_UV_STOP) begin
        undervolt_stop_notice <= 1'b1;
        fault_code            <= DBP_CODE_UV_STOP;
      end else if (state_reg == DBP_ST_UV_FAULT && state_next != DBP_ST_UV_FAULT) begin
        undervolt_fault <= 1'b0;
        fault_code      <= DBP_CODE_NONE;
        auto_restart    <= state_next == DBP_ST_RUN;
      end else if (state_reg == DBP_ST_UV_STOP && state_next == DBP_ST_STOP) begin
        undervolt_stop_notice <= 1'b0;
        fault_code            <= DBP_CODE_NONE;
        auto_restart          <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Stall prevention.
  // ************************************************************
  // Over-voltage hold: traditional and smart both pause above trip level; near it smart only stretches.
  assign ov_hold = state_reg == DBP_ST_RUN && ramp_decel && ov_en && ov_above;
  assign oc_hold = state_reg == DBP_ST_RUN && ramp_accel && oc_above;

  // Once overvoltage shows while stopping in smart mode, stretch until standstill.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_latch_reg <= 1'b0;
    end else if (motor_stopped || !ramp_decel_to_stop || !smart || !ov_en) begin
      stretch_latch_reg <= 1'b0;
    end else if (ov_above) begin
      stretch_latch_reg <= 1'b1;
    end
  end

  // Ramp hold and stretch outputs, registered on the edge after the compare.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_hold     <= 1'b0;
      decel_stretch <= 1'b0;
    end else begin
      ramp_hold     <= ov_hold || oc_hold;
      decel_stretch <= state_reg == DBP_ST_RUN && ramp_decel && ov_en && smart &&
                       (ov_near || stretch_latch_reg);
    end
  end

  // ************************************************************
  // Interrupts.
  // ************************************************************
  assign irq_event[`DBP_IRQ_UV_RUN]   = state_reg == DBP_ST_RUN && state_next == DBP_ST_UV_FAULT;
  assign irq_event[`DBP_IRQ_UV_STOP]  = state_reg == DBP_ST_STOP && state_next == DBP_ST_UV_STOP;
  assign irq_event[`DBP_IRQ_OV_STALL] = ov_hold && !ramp_hold;
  assign irq_event[`DBP_IRQ_OC_STALL] = oc_hold && !ramp_hold;
  assign irq_event[`DBP_IRQ_RESTART]  = (state_reg == DBP_ST_UV_FAULT && state_next == DBP_ST_RUN) ||
                                        (state_reg == DBP_ST_UV_STOP && state_next == DBP_ST_STOP);

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_reg <= '0;
    end else if (apb_wr && idx == `DBP_IDX_IRQ_STS) begin
      irq_sts_reg <= (irq_sts_reg & ~pwdata[`DBP_IRQ_W-1:0]) | irq_event;
    end else begin
      irq_sts_reg <= irq_sts_reg | irq_event;
    end
  end

  // Interrupt level from unmasked status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  // ************************************************************
  // APB slave.
  // ************************************************************
  assign idx       = paddr[13:2];
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite && !pslverr;

  // Writable registers; updates land at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_thr_reg     <= UV_DEF;
      ov_thr_reg     <= OV_DEF;
      ov_method_reg  <= `DBP_OV_METHOD_DEF;
      oc_thr_reg     <= `DBP_OC_DEF_VT;
      restart_en_reg <= 1'b0;
      torque_ct_reg  <= 1'b0;
      irq_mask_reg   <= '0;
    end else if (apb_wr) begin
      case (idx)
        `DBP_IDX_UV_THR:    uv_thr_reg    <= pwdata[15:0];
        `DBP_IDX_OV_THR:    ov_thr_reg    <= pwdata[15:0];
        `DBP_IDX_OV_METHOD: ov_method_reg <= {15'h0000, pwdata[0]};
        `DBP_IDX_OC_THR:    oc_thr_reg    <= pwdata[15:0];
        `DBP_IDX_CTRL: begin
          restart_en_reg <= pwdata[`DBP_CTRL_RESTART_EN];
          torque_ct_reg  <= pwdata[`DBP_CTRL_TORQUE_CT];
        end
        `DBP_IDX_IRQ_MASK:  irq_mask_reg  <= pwdata[`DBP_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Ready, error and read data are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (apb_setup) begin
        case (idx)
          `DBP_IDX_UV_THR:    prdata <= {16'h0000, uv_thr_reg};
          `DBP_IDX_OV_THR:    prdata <= {16'h0000, ov_thr_reg};
          `DBP_IDX_OV_METHOD: prdata <= {16'h0000, ov_method_reg};
          `DBP_IDX_OC_THR:    prdata <= {16'h0000, oc_thr_reg};
          `DBP_IDX_CTRL:      prdata <= {29'h00000000, torque_ct_reg, restart_en_reg, 1'b0};
          `DBP_IDX_STATE:     prdata <= {23'h000000, stretch_latch_reg, ramp_hold,
                                         state_reg, fault_code, undervolt_stop_notice,
                                         undervolt_fault};
          `DBP_IDX_IRQ_STS:   prdata <= {27'h0000000, irq_sts_reg};
          `DBP_IDX_IRQ_MASK:  prdata <= {27'h0000000, irq_mask_reg};
          default:            pslverr <= 1'b1;
        endcase
        if (paddr[15:14] != 2'h0 || paddr[1:0] != 2'h0) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : dbp_top
